// ### logic/rcss_seq.sv
// Implementation choices: the address map and the address-and-strobe port.
`include "rcss_consts.svh"

module rcss_seq
   import rcss_pkg::*;
#(
   parameter int unsigned LIGHT_CYCLES = `RCSS_CYC(`RCSS_LIGHT_TIME_NS),
   parameter int unsigned PAUSE_CYCLES = `RCSS_CYC(`RCSS_PAUSE_TIME_NS),
   parameter int unsigned FAST_CYCLES = `RCSS_CYC(`RCSS_FAST_TIME_NS),
   parameter int unsigned SLOW_CYCLES = `RCSS_CYC(`RCSS_SLOW_TIME_NS)
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic trim_load_done_i,
   input wire logic supply_above_switch_start_i,
   input wire logic supply_below_restart_i,
   input wire logic bulk_start_ok_i,
   input wire logic feedback_below_burst_level_i,
   input wire logic soft_start_done_i,
   input wire rcss_faults_t faults_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o,
   output rcss_enables_t enables_o,
   output logic low_side_charge_o,
   output rcss_state_t state_o
);

   localparam int unsigned WAKE_CYCLES = `RCSS_WAKE_CYC;
   localparam int unsigned BOOT_CYCLES = `RCSS_BOOT_CYC;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // refused at elaboration: every interval counter assumes at least two cycles
   if (LIGHT_CYCLES < 2 || PAUSE_CYCLES < 2) begin : g_bad_counts
      $error("rcss_seq: counts too small");
   end
   if (FAST_CYCLES < 2 || SLOW_CYCLES < 2) begin : g_bad_timers
      $error("rcss_seq: fault timers too small");
   end

   rcss_seq_t q, d;
   logic fast_to;
   logic slow_to;
   logic early_fault;
   logic run_fault;
   logic [`RCSS_EV_W-1:0] ev;
   logic [`RCSS_EV_W-1:0] w1c;

   // ------------------------------------------------------------
   // average-current fault timers
   // ------------------------------------------------------------
   // the fault only counts once it has been held for the full window
   rcss_timer #(
      .CYCLES(FAST_CYCLES)
   ) u_fast_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(faults_i.avg_current_fault_fast),
      .expired_o(fast_to)
   );

   rcss_timer #(
      .CYCLES(SLOW_CYCLES)
   ) u_slow_timer (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(faults_i.avg_current_fault_slow),
      .expired_o(slow_to)
   );

   // fault groups: only overtemp and bulk overvoltage stop the early states
   assign early_fault = faults_i.overtemp_fault | faults_i.bulk_overvoltage;
   assign run_fault = early_fault | faults_i.bulk_below_stop |
      faults_i.output_overvoltage_fault | faults_i.peak_current_fault |
      fast_to | slow_to | faults_i.reg_supply_undervoltage;

   // enable pattern belonging to each state
   function automatic rcss_enables_t en_of(input rcss_state_t s);
      rcss_enables_t e;
      e = `RCSS_EN_OFF;
      case (s)
         ST_STARTUP: e = `RCSS_EN_STARTUP;
         ST_PASS_ON: e = `RCSS_EN_PASS_ON;
         ST_PASS_OFF, ST_WAKEUP, ST_BOOT: e = `RCSS_EN_SUPPLY;
         ST_RUN, ST_LIGHT: e = `RCSS_EN_RUN;
         ST_FAULT: e = `RCSS_EN_OFF;
         default: e = `RCSS_EN_OFF;
      endcase
      return e;
   endfunction : en_of

   // ------------------------------------------------------------
   // sequencer, fault pause and register file
   // ------------------------------------------------------------
   // priority: fault, then supply restart, then forward progress
   always_comb begin
      d = q;
      ev = '0;
      w1c = '0;
      d.rdata = '0;
      d.cnt = q.cnt + 32'h1;
      case (q.st)
         ST_STARTUP: begin
            if (faults_i.overtemp_fault) begin
               d.st = ST_FAULT;
            end else if (trim_load_done_i) begin
               d.st = ST_PASS_ON;
            end
         end
         ST_PASS_ON: begin
            if (early_fault) begin
               d.st = ST_FAULT;
            end else if (supply_above_switch_start_i && !supply_below_restart_i) begin
               d.st = ST_PASS_OFF;
            end
         end
         ST_PASS_OFF: begin
            if (early_fault) begin
               d.st = ST_FAULT;
            end else if (supply_below_restart_i) begin
               d.st = ST_PASS_ON;
            end else if (bulk_start_ok_i && !faults_i.bulk_below_stop &&
                         !faults_i.reg_supply_undervoltage) begin
               d.st = ST_WAKEUP;
            end
         end
         ST_WAKEUP: begin
            if (early_fault) begin
               d.st = ST_FAULT;
            end else if (supply_below_restart_i) begin
               d.st = ST_PASS_ON;
            end else if (q.cnt == WAKE_CYCLES - 1) begin
               d.st = ST_BOOT;
            end
         end
         ST_BOOT: begin
            if (early_fault) begin
               d.st = ST_FAULT;
            end else if (supply_below_restart_i) begin
               d.st = ST_PASS_ON;
            end else if (q.cnt == BOOT_CYCLES - 1) begin
               d.st = ST_RUN;
            end
         end
         ST_RUN: begin
            if (run_fault) begin
               d.st = ST_FAULT;
            end else if (supply_below_restart_i) begin
               d.st = ST_PASS_ON;
            end else if (soft_start_done_i && feedback_below_burst_level_i) begin
               d.st = ST_LIGHT;
            end
         end
         ST_LIGHT: begin
            if (run_fault) begin
               d.st = ST_FAULT;
            end else if (supply_below_restart_i) begin
               d.st = ST_PASS_ON;
            end else if (!feedback_below_burst_level_i) begin
               d.st = ST_RUN;
            end else if (q.cnt == LIGHT_CYCLES - 1) begin
               d.st = ST_FAULT;
               ev[`RCSS_EV_LIGHT_TO] = 1'b1;
            end
         end
         ST_FAULT: begin
            // the restart skips the startup state, even after an over-temperature fault taken there before trim load done
            if (q.cnt == PAUSE_CYCLES - 1) begin
               d.st = ST_PASS_ON;
            end
         end
         default: d.st = ST_STARTUP;
      endcase
      // the count measures time spent in the current state
      if (d.st != q.st) begin
         d.cnt = '0;
         ev[`RCSS_EV_FAULT] = (d.st == ST_FAULT);
         ev[`RCSS_EV_RESTART] = (d.st == ST_PASS_ON) && (q.st != ST_STARTUP) &&
            (q.st != ST_FAULT);
         ev[`RCSS_EV_RUN] = (d.st == ST_RUN) && (q.st == ST_BOOT);
      end
      // enables follow the next state so they move on the transition edge
      d.en = en_of(d.st);
      d.low_side = (d.st == ST_BOOT);
      // discharge of the line capacitor is handled elsewhere, never here
      if (reg_wr_i && reg_addr_i == `RCSS_REG_STATUS) begin
         w1c = reg_wdata_i[`RCSS_EV_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == `RCSS_REG_MASK) begin
         d.mask = reg_wdata_i[`RCSS_EV_W-1:0];
      end
      // a new event beats a clear in the same cycle
      d.status = (q.status & ~w1c) | ev;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `RCSS_REG_STATUS: d.rdata = {28'h0, q.status};
            `RCSS_REG_MASK: d.rdata = {28'h0, q.mask};
            `RCSS_REG_STATE: d.rdata = {20'h0, q.low_side, q.en, 3'h0, q.st};
            default: d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.en <= `RCSS_EN_STARTUP;
      end else begin
         q <= d;
      end
   end

   assign enables_o = q.en;
   assign low_side_charge_o = q.low_side;
   assign state_o = q.st;
   assign reg_rdata_o = q.rdata;
   assign irq_o = |(q.status & q.mask);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_reset_startup: assert property ($past(sys_rst_i) |->
      q.st == ST_STARTUP && enables_o == rcss_enables_t'(`RCSS_EN_STARTUP))
      else $error("startup state or enables wrong after reset");

   a_wait_trim: assert property (q.st == ST_STARTUP && !trim_load_done_i &&
      !faults_i.overtemp_fault |=> q.st == ST_STARTUP)
      else $error("left startup before trim load done");

   a_pass_on_outs: assert property (q.st == ST_PASS_ON |->
      enables_o == rcss_enables_t'(`RCSS_EN_PASS_ON) && !low_side_charge_o)
      else $error("pass-on enables wrong");

   a_pass_off_entry: assert property (q.st == ST_PASS_ON && !early_fault &&
      supply_above_switch_start_i && !supply_below_restart_i |=>
      q.st == ST_PASS_OFF && enables_o == rcss_enables_t'(`RCSS_EN_SUPPLY))
      else $error("pass switch not released");

   a_wake_length: assert property (q.st == ST_BOOT && $past(q.st) == ST_WAKEUP |->
      $past(q.cnt) == WAKE_CYCLES - 1)
      else $error("wake-up interval wrong");

   a_boot_charge: assert property (q.st == ST_BOOT |-> low_side_charge_o &&
      enables_o == rcss_enables_t'(`RCSS_EN_SUPPLY))
      else $error("boot charge outputs wrong");

   a_boot_length: assert property (q.st == ST_RUN && $past(q.st) == ST_BOOT |->
      $past(q.cnt) == BOOT_CYCLES - 1)
      else $error("boot interval wrong");

   a_run_outs: assert property (q.st inside {ST_RUN, ST_LIGHT} |->
      enables_o == rcss_enables_t'(`RCSS_EN_RUN))
      else $error("run enables wrong");

   a_light_entry: assert property (q.st == ST_RUN && !run_fault &&
      !supply_below_restart_i && soft_start_done_i && feedback_below_burst_level_i
      |=> q.st == ST_LIGHT)
      else $error("light load not entered");

   a_light_timeout: assert property (q.st == ST_LIGHT && !run_fault &&
      !supply_below_restart_i && feedback_below_burst_level_i &&
      q.cnt == LIGHT_CYCLES - 1 |=> q.st == ST_FAULT && q.status[`RCSS_EV_LIGHT_TO])
      else $error("light load timeout missed");

   a_fault_pause: assert property (q.st == ST_PASS_ON && $past(q.st) == ST_FAULT |->
      $past(q.cnt) == PAUSE_CYCLES - 1 && $past(enables_o) == '0)
      else $error("fault pause wrong");

   a_run_fault: assert property (q.st inside {ST_RUN, ST_LIGHT} && run_fault
      |=> q.st == ST_FAULT && enables_o == '0)
      else $error("run fault not taken");

   a_fast_timer: assert property ($rose(fast_to) |->
      $past(faults_i.avg_current_fault_fast) && $past(u_fast_timer.q.cnt) == FAST_CYCLES - 1)
      else $error("fast timer expired without held fault");

   a_slow_timer: assert property ($rose(slow_to) |->
      $past(faults_i.avg_current_fault_slow) && $past(u_slow_timer.q.cnt) == SLOW_CYCLES - 1)
      else $error("slow timer expired without held fault");

   a_restart: assert property (q.st inside {ST_PASS_OFF, ST_WAKEUP, ST_BOOT} &&
      !early_fault && supply_below_restart_i |=> q.st == ST_PASS_ON &&
      enables_o.hv_pass_switch_on)
      else $error("supply restart not taken");

   a_enables_edge: assert property (!$stable(enables_o) |->
      !$stable(q.st) && enables_o == en_of(q.st))
      else $error("enables moved without a transition");

   // remaining transitions, each with the priority of fault over restart over progress
   a_startup_fault: assert property (q.st == ST_STARTUP && faults_i.overtemp_fault |=>
      q.st == ST_FAULT)
      else $error("over-temperature ignored in startup");

   a_early_fault: assert property (early_fault &&
      q.st inside {ST_PASS_ON, ST_PASS_OFF, ST_WAKEUP, ST_BOOT} |=>
      q.st == ST_FAULT && enables_o == '0)
      else $error("early fault not taken");

   a_pass_on_hold: assert property (q.st == ST_PASS_ON && !early_fault &&
      !supply_above_switch_start_i |=> q.st == ST_PASS_ON && enables_o.hv_pass_switch_on)
      else $error("pass-on state left early");

   a_wake_entry: assert property (q.st == ST_PASS_OFF && !early_fault &&
      !supply_below_restart_i && bulk_start_ok_i && !faults_i.bulk_below_stop &&
      !faults_i.reg_supply_undervoltage |=> q.st == ST_WAKEUP)
      else $error("wake-up not entered");

   a_light_exit: assert property (q.st == ST_LIGHT && !run_fault &&
      !supply_below_restart_i && !feedback_below_burst_level_i |=> q.st == ST_RUN)
      else $error("light load not left");

   a_run_restart: assert property (q.st inside {ST_RUN, ST_LIGHT} && !run_fault &&
      supply_below_restart_i |=> q.st == ST_PASS_ON && q.status[`RCSS_EV_RESTART])
      else $error("restart from run not taken");

   a_fault_hold: assert property (q.st == ST_FAULT && q.cnt != PAUSE_CYCLES - 1 |=>
      q.st == ST_FAULT && enables_o == '0)
      else $error("fault pause cut short");

   a_fault_flag: assert property (q.st != ST_FAULT ##1 q.st == ST_FAULT |->
      q.status[`RCSS_EV_FAULT])
      else $error("fault entry not flagged");

   a_low_side_only: assert property (low_side_charge_o |-> q.st == ST_BOOT)
      else $error("low side on outside boot charge");

   c_reach_run: cover property (q.st == ST_BOOT ##1 q.st == ST_RUN);
   c_light_back: cover property (q.st == ST_LIGHT ##1 q.st == ST_RUN);
   c_fault_restart: cover property (q.st == ST_FAULT ##1 q.st == ST_PASS_ON);
   c_irq: cover property (irq_o && q.status[`RCSS_EV_FAULT]);
   c_restart_run: cover property (q.st == ST_RUN ##1 q.st == ST_PASS_ON);

endmodule : rcss_seq

// ### logic/rcss_consts.svh
// Functional notes
// - reset enters startup: clamp and pass on
// - leave startup for pass-on only once trim load done
// - pass-on state: pass switch on, clamp off
// - supply up, not low: pass off, supply on
// - bulk good: wake-up for 150us
// - boot charge: low side on, fixed interval
// - run: waveform, supply, soft start enabled
// - feedback below burst level: light load
// - light load over 200ms is fault
// - fault: all off, wait 1s, restart
// - listed faults end run; otp/ov end startup (ov ignored in startup state)
// - capacitor discharge independent of this sequencer
// - restart input high while supply below threshold
// - fast average-current fault after 2ms
// - slow average-current fault after 50ms
`ifndef RCSS_CONSTS_SVH
`define RCSS_CONSTS_SVH

// ------------------------------------------------------------
// clock and times
// ------------------------------------------------------------
`define RCSS_CLK_PERIOD_NS 50
`define RCSS_WAKE_TIME_NS 150000
`define RCSS_LIGHT_TIME_NS 200000000
`define RCSS_PAUSE_TIME_NS 1000000000
`define RCSS_FAST_TIME_NS 2000000
`define RCSS_SLOW_TIME_NS 50000000
`define RCSS_CYC(t) (((t) + `RCSS_CLK_PERIOD_NS - 1) / `RCSS_CLK_PERIOD_NS)
`define RCSS_WAKE_CYC `RCSS_CYC(`RCSS_WAKE_TIME_NS)
`define RCSS_BOOT_CYC 200

// ------------------------------------------------------------
// enable patterns {wave, rvcc, clamp, soft start, pass switch}
// ------------------------------------------------------------
`define RCSS_EN_STARTUP 5'h05
`define RCSS_EN_PASS_ON 5'h01
`define RCSS_EN_SUPPLY 5'h08
`define RCSS_EN_RUN 5'h1a
`define RCSS_EN_OFF 5'h00

// ------------------------------------------------------------
// registers and status bits
// ------------------------------------------------------------
`define RCSS_REG_STATUS 4'h0
`define RCSS_REG_MASK 4'h4
`define RCSS_REG_STATE 4'h8
`define RCSS_EV_FAULT 0
`define RCSS_EV_LIGHT_TO 1
`define RCSS_EV_RESTART 2
`define RCSS_EV_RUN 3
`define RCSS_EV_W 4

`endif

// ### logic/rcss_pkg.sv
package rcss_pkg;

   // ------------------------------------------------------------
   // carriers and state types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_STARTUP,
      ST_PASS_ON,
      ST_PASS_OFF,
      ST_WAKEUP,
      ST_BOOT,
      ST_RUN,
      ST_LIGHT,
      ST_FAULT
   } rcss_state_t;

   typedef struct packed {
      logic waveform_gen_enable;
      logic regulated_supply_enable;
      logic supply_clamp_enable;
      logic soft_start_enable;
      logic hv_pass_switch_on;
   } rcss_enables_t;

   typedef struct packed {
      logic overtemp_fault;
      logic bulk_overvoltage;
      logic bulk_below_stop;
      logic output_overvoltage_fault;
      logic peak_current_fault;
      logic avg_current_fault_fast;
      logic avg_current_fault_slow;
      logic reg_supply_undervoltage;
   } rcss_faults_t;

   typedef struct packed {
      logic [31:0] cnt;
      logic expired;
   } rcss_timer_t;

   typedef struct packed {
      rcss_state_t st;
      logic [31:0] cnt;
      rcss_enables_t en;
      logic low_side;
      logic [3:0] status;
      logic [3:0] mask;
      logic [31:0] rdata;
   } rcss_seq_t;

endpackage : rcss_pkg

// ### logic/rcss_timer.sv
module rcss_timer
   import rcss_pkg::*;
#(
   parameter int unsigned CYCLES = 40000
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic run_i,
   output logic expired_o
);

   rcss_timer_t q, d;

   // refused at elaboration: the counter needs at least two cycles per window
   if (CYCLES < 2) begin : g_bad_cycles
      $error("rcss_timer: CYCLES must be at least 2");
   end

   // counts cycles of a continuously held input; any drop restarts it
   always_comb begin
      d = q;
      if (!run_i) begin
         d.cnt = '0;
         d.expired = 1'b0;
      end else if (q.cnt == CYCLES - 1) begin
         d.expired = 1'b1;
      end else begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expired_o = q.expired;

endmodule : rcss_timer

// ### bench/rcss_analog_model.sv
// ------------------------------------------------------------
// far side: supply comparators and soft start ramp
// ------------------------------------------------------------
module rcss_analog_model
   import rcss_pkg::*;
#(
   parameter logic [7:0] RESTART_LVL = 8'h40,
   parameter logic [7:0] START_LVL = 8'h80,
   parameter int unsigned SS_CYC = 20
) (
   input wire logic clk_i,
   input wire logic [7:0] supply_level_i,
   input wire rcss_enables_t enables_i,
   output logic supply_below_restart_o,
   output logic supply_above_switch_start_o,
   output logic soft_start_done_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int unsigned ss_cnt = 0;

   // two thresholds apart, so the comparators never both read high
   assign supply_below_restart_o = (supply_level_i < RESTART_LVL);
   assign supply_above_switch_start_o = (supply_level_i >= START_LVL);

   // ramp restarts whenever the enable drops, as a real capacitor would
   always @(posedge clk_i) begin
      if (!enables_i.soft_start_enable) begin
         ss_cnt <= 0;
      end else if (ss_cnt < SS_CYC) begin
         ss_cnt <= ss_cnt + 1;
      end
   end
   assign soft_start_done_o = (ss_cnt >= SS_CYC);
endmodule : rcss_analog_model

// ### bench/rcss_seq_tb_top.sv
`include "rcss_consts.svh"

module rcss_seq_tb_top import rcss_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // shortened light, pause and fault timer counts keep the run well under the cycle budget
   // ------------------------------------------------------------
   localparam int LIGHT = 40;
   localparam int PAUSE = 50;
   localparam int FAST = 8;
   localparam int SLOW = 16;
   localparam int SS = 20;
   localparam int WAKE = 3000;
   localparam int BOOT = 200;
   localparam logic [7:0] LVL_LO = 8'h20;
   localparam logic [7:0] LVL_HI = 8'hc0;

   logic clk, rst, trim, bulk, fb, wr, rd, irq, low_side, below, above, ss_done;
   logic [7:0] lvl;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   rcss_faults_t flt;
   rcss_enables_t en;
   rcss_state_t st;
   int n_mismatch = 0;
   int cmp_count = 0;

   typedef struct {
      rcss_faults_t f;
      logic drop;
      rcss_state_t exp;
      int lo;
      int hi;
      logic [3:0] sts;
   } rcss_row_t;

   // one disturbance per row, applied in run
   rcss_row_t rows[9] = '{
      '{8'h80, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h40, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h20, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h10, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h08, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h01, 1'b0, ST_FAULT, 0, 3, 4'h9},
      '{8'h04, 1'b0, ST_FAULT, FAST - 1, FAST + 6, 4'h9},
      '{8'h02, 1'b0, ST_FAULT, SLOW - 1, SLOW + 6, 4'h9},
      '{8'h00, 1'b1, ST_PASS_ON, 0, 3, 4'hc}
   };

   rcss_seq #(.LIGHT_CYCLES(LIGHT), .PAUSE_CYCLES(PAUSE), .FAST_CYCLES(FAST),
      .SLOW_CYCLES(SLOW)) dut (.clk_i(clk), .sys_rst_i(rst), .trim_load_done_i(trim),
      .supply_above_switch_start_i(above), .supply_below_restart_i(below),
      .bulk_start_ok_i(bulk), .feedback_below_burst_level_i(fb),
      .soft_start_done_i(ss_done), .faults_i(flt), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .irq_o(irq), .enables_o(en), .low_side_charge_o(low_side), .state_o(st));

   rcss_analog_model #(.SS_CYC(SS)) partner (.clk_i(clk), .supply_level_i(lvl),
      .enables_i(en), .supply_below_restart_o(below),
      .supply_above_switch_start_o(above), .soft_start_done_o(ss_done));

   // ------------------------------------------------------------
   // clock, checks and bus tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : reg_write

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", exp, rdata);
   endtask : reg_read

   // arrival must fall inside the window [lo, hi) of edges
   task automatic expect_st(input rcss_state_t exp, input int lo, input int hi);
      int i;
      for (i = 0; i < hi; i++) begin
         @(posedge clk);
         #1;
         if (st === exp) break;
      end
      chk("state", 32'(exp), 32'(st));
      if (i < lo) chk("state_early", 32'(lo), 32'(i));
   endtask : expect_st

   task automatic do_reset(input int n);
      @(posedge clk);
      rst <= 1'b1;
      trim <= 1'b0;
      lvl <= LVL_LO;
      bulk <= 1'b0;
      fb <= 1'b0;
      flt <= '0;
      repeat (n) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // full start-up walk, checking every stage's enables on the way
   task automatic bring_up();
      do_reset(2);
      repeat (3) @(posedge clk);
      #1 chk("startup_hold", 32'(ST_STARTUP), 32'(st));
      chk("en_startup", `RCSS_EN_STARTUP, 32'(en));
      @(posedge clk) trim <= 1'b1;
      expect_st(ST_PASS_ON, 0, 3);
      chk("en_pass_on", `RCSS_EN_PASS_ON, 32'(en));
      @(posedge clk) lvl <= LVL_HI;
      expect_st(ST_PASS_OFF, 0, 3);
      chk("en_pass_off", `RCSS_EN_SUPPLY, 32'(en));
      @(posedge clk) bulk <= 1'b1;
      expect_st(ST_WAKEUP, 0, 3);
      chk("en_wake", `RCSS_EN_SUPPLY, 32'(en));
      expect_st(ST_BOOT, WAKE - 3, WAKE + 5);
      chk("low_side_boot", 32'h1, 32'(low_side));
      chk("en_boot", `RCSS_EN_SUPPLY, 32'(en));
      expect_st(ST_RUN, BOOT - 3, BOOT + 5);
      chk("en_run", `RCSS_EN_RUN, 32'(en));
      chk("low_side_run", 32'h0, 32'(low_side));
   endtask : bring_up

   // ------------------------------------------------------------
   // watchdog: ten start-ups of about 3300 cycles plus margin
   // ------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      trim = 1'b0;
      lvl = LVL_LO;
      bulk = 1'b0;
      fb = 1'b0;
      flt = '0;
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      do_reset(20);
      foreach (rows[k]) begin
         bring_up();
         reg_write(`RCSS_REG_MASK, 32'h0000_0001);
         @(posedge clk);
         flt <= rows[k].f;
         if (rows[k].drop) lvl <= LVL_LO;
         expect_st(rows[k].exp, rows[k].lo, rows[k].hi);
         reg_read(`RCSS_REG_STATUS, 32'(rows[k].sts));
         chk("irq", 32'(rows[k].sts[0]), 32'(irq));
         if (rows[k].exp == ST_FAULT) chk("en_fault", `RCSS_EN_OFF, 32'(en));
      end
      // light load must wait for soft start, then time out into a pause
      bring_up();
      @(posedge clk) fb <= 1'b1;
      repeat (SS - 5) @(posedge clk);
      #1 chk("light_early", 32'(ST_RUN), 32'(st));
      expect_st(ST_LIGHT, 0, 12);
      chk("en_light", `RCSS_EN_RUN, 32'(en));
      @(posedge clk) fb <= 1'b0;
      expect_st(ST_RUN, 0, 3);
      @(posedge clk) fb <= 1'b1;
      expect_st(ST_LIGHT, 0, 3);
      expect_st(ST_FAULT, LIGHT - 3, LIGHT + 6);
      chk("en_fault", `RCSS_EN_OFF, 32'(en));
      expect_st(ST_PASS_ON, PAUSE - 3, PAUSE + 6);
      chk("en_restart", `RCSS_EN_PASS_ON, 32'(en));
      // mask, clear by writing one, unmapped place reads zero
      reg_write(`RCSS_REG_MASK, 32'h0000_0002);
      chk("irq_masked_in", 32'h1, 32'(irq));
      reg_write(`RCSS_REG_STATUS, 32'h0000_0002);
      chk("irq_cleared", 32'h0, 32'(irq));
      reg_read(`RCSS_REG_STATUS, 32'h0000_0009);
      reg_read(`RCSS_REG_MASK, 32'h0000_0002);
      reg_read(4'hc, 32'h0);
      // restart went on to wake-up: supply enable only, low side off
      reg_read(`RCSS_REG_STATE, 32'h0000_0203);
      @(posedge clk);
      #1 chk("rdata_idle", 32'h0, rdata);
      // early states: over-temperature and bulk overvoltage only
      do_reset(2);
      @(posedge clk) flt.overtemp_fault <= 1'b1;
      expect_st(ST_FAULT, 0, 3);
      do_reset(2);
      @(posedge clk) trim <= 1'b1;
      expect_st(ST_PASS_ON, 0, 3);
      @(posedge clk) flt.bulk_overvoltage <= 1'b1;
      expect_st(ST_FAULT, 0, 3);
      do_reset(2);
      @(posedge clk) trim <= 1'b1;
      lvl <= LVL_HI;
      bulk <= 1'b1;
      flt.bulk_below_stop <= 1'b1;
      repeat (10) @(posedge clk);
      #1 chk("bulk_stop_hold", 32'(ST_PASS_OFF), 32'(st));
      // supply sags before wake-up: back to the pass switch
      @(posedge clk) lvl <= LVL_LO;
      expect_st(ST_PASS_ON, 0, 3);
      chk("en_back_on", `RCSS_EN_PASS_ON, 32'(en));
      final_report();
   end
endmodule : rcss_seq_tb_top
